// File: design/board_test_pkg.sv
// Constants for the board test mode control block
// Functional notes
// - Power-good low enters high-impedance test mode
// - Power-good low floats outputs, fast clock low
// - Slow clock output keeps following slow oscillator
// - Code captured on strobe rising edge
// - Connectivity mode: pins feed one AND tree
// - Speaker high only when all tree inputs high
// - Speaker, strobe, power-good, oscillators excluded
// - Power-good low pulse leaves connectivity mode
// - Repeated entry with code 00h also exits
package board_test_pkg;

	localparam int PIN_COUNT = 32;
	localparam int DATA_WIDTH = 8;
	localparam logic [7:0] CODE_CONNECT = 8'hFE;
	localparam logic [7:0] CODE_EXIT = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// Each filtered input: 3 stage flops and an output flop, change taken when stages 2 and 3 agree
	localparam int SYNC_STAGES = 3;

	// Tester setup/hold on the data bus, and the clock it is measured in
	localparam int CLOCK_PERIOD_NS = 20;
	localparam int SETUP_HOLD_NS = 50;
	localparam int SETUP_HOLD_CYCLES =
		(SETUP_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b001,
		MODE_HIZ = 3'b010,
		MODE_CONNECT = 3'b100
	} test_mode_t;

endpackage

// File: design/pin_filter.sv
// Three-stage synchroniser and agreement filter for asynchronous pins
`timescale 1ns/1ns
module pin_filter #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] filtered_q
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;

	// Stages start at the idle level too, so no false edge follows reset
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stage1_q <= RESET_VALUE;
			stage2_q <= RESET_VALUE;
			stage3_q <= RESET_VALUE;
		end else begin
			stage1_q <= async_in;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
		end
	end

	// Stage 1 feeds stage 2 only; a bit moves once stages 2 and 3 agree
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			filtered_q <= RESET_VALUE;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_q[i] == stage3_q[i]) begin
					filtered_q[i] <= stage3_q[i];
				end
			end
		end
	end

endmodule

// File: design/board_test_mode_control.sv
// Board test mode control: high-impedance and AND-tree connectivity modes
`timescale 1ns/1ns
module board_test_mode_control #(
	parameter int PINS = board_test_pkg::PIN_COUNT
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic power_ok_input,
	input wire logic gate_a20_mask_pin,
	input wire logic [board_test_pkg::DATA_WIDTH-1:0] peripheral_data_bus,
	input wire logic standby_reset_n,
	input wire logic fast_clock_source,
	input wire logic slow_osc_in,
	input wire logic [PINS-1:0] core_pin_out,
	input wire logic [PINS-1:0] core_pin_oe,
	input wire logic core_speaker_out,
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	output logic speaker_out,
	output logic speaker_oe,
	output logic fast_osc_out,
	output logic slow_osc_out,
	output logic hiz_active,
	output logic connect_active,
	output logic [board_test_pkg::DATA_WIDTH-1:0] captured_code
);
	import board_test_pkg::*;

	localparam int FILT_W = PINS + DATA_WIDTH + 4;
	localparam logic [FILT_W-1:0] FILT_RESET = {
		{PINS{1'b1}}, DATA_RESET, 4'b1110};

	logic [FILT_W-1:0] filt_q;
	logic power_ok_f;
	logic strobe_n_f;
	logic standby_reset_n_f;
	logic slow_osc_f;
	logic [DATA_WIDTH-1:0] data_f;
	logic [PINS-1:0] pin_in_f;
	logic strobe_prev_q;
	logic power_prev_q;
	logic strobe_rise;
	logic power_fall;
	logic [DATA_WIDTH-1:0] data_hold_q;
	logic [DATA_WIDTH-1:0] code_q;
	logic [DATA_WIDTH-1:0] code_d;
	logic power_seen_high_q;
	logic tree_result;
	test_mode_t mode_q;
	test_mode_t mode_d;

	// Where the block settles once no test is pending
	function automatic test_mode_t rest_mode(input logic power_high);
		return power_high ? MODE_NORMAL : MODE_HIZ;
	endfunction

	// Pads and the fast clock follow the core only in normal operation
	function automatic logic pads_live(input test_mode_t m);
		return m == MODE_NORMAL;
	endfunction

	// Power-good resets high so a chip coming out of reset is not in Hi-Z
	pin_filter #(
		.WIDTH(FILT_W),
		.RESET_VALUE(FILT_RESET)
	) u_filter (
		.clock(clock),
		.resetn(resetn),
		.async_in({pin_in, peripheral_data_bus, power_ok_input,
			gate_a20_mask_pin, standby_reset_n, slow_osc_in}),
		.filtered_q(filt_q)
	);

	assign pin_in_f = filt_q[FILT_W-1 -: PINS];
	assign data_f = filt_q[3+DATA_WIDTH -: DATA_WIDTH];
	assign power_ok_f = filt_q[3];
	assign strobe_n_f = filt_q[2];
	assign standby_reset_n_f = filt_q[1];
	assign slow_osc_f = filt_q[0];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strobe_prev_q <= 1'b1;
			power_prev_q <= 1'b1;
		end else begin
			strobe_prev_q <= strobe_n_f;
			power_prev_q <= power_ok_f;
		end
	end

	assign strobe_rise = strobe_n_f && !strobe_prev_q;
	assign power_fall = !power_ok_f && power_prev_q;

	// The bus is followed only while the strobe is low, so the value held
	// at the rising edge is the one the tester set up, not a later change
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			data_hold_q <= DATA_RESET;
		end else if (!strobe_n_f) begin
			data_hold_q <= data_f;
		end
	end

	// The output register takes the next code, so it changes on the same
	// edge as the mode that the code selects
	assign code_d = strobe_rise ? data_hold_q : code_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			code_q <= DATA_RESET;
		end else begin
			code_q <= code_d;
		end
	end

	// Exit by power-good needs a low pulse after the entry low ended
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			power_seen_high_q <= 1'b0;
		end else if (mode_q != MODE_CONNECT) begin
			power_seen_high_q <= 1'b0;
		end else if (power_ok_f) begin
			power_seen_high_q <= 1'b1;
		end
	end

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			MODE_NORMAL: begin
				if (!power_ok_f) begin
					mode_d = MODE_HIZ;
				end
			end
			MODE_HIZ: begin
				if (strobe_rise && data_hold_q == CODE_CONNECT) begin
					mode_d = MODE_CONNECT;
				end else if (power_ok_f) begin
					mode_d = MODE_NORMAL;
				end
			end
			MODE_CONNECT: begin
				if (strobe_rise && data_hold_q == CODE_EXIT) begin
					mode_d = rest_mode(power_ok_f);
				end else if (power_fall && power_seen_high_q) begin
					mode_d = MODE_HIZ;
				end
			end
			default: begin
				mode_d = rest_mode(power_ok_f);
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mode_q <= MODE_NORMAL;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Every pin but speaker, strobe, power-good and oscillators; the code
	// bus and the standby reset pin count as ordinary tree inputs
	assign tree_result = &pin_in_f
		&& &data_f
		&& standby_reset_n_f;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin_out <= '0;
			pin_oe <= '0;
		end else begin
			pin_out <= core_pin_out;
			// Floated in both test modes; in connectivity they are inputs
			pin_oe <= pads_live(mode_d) ? core_pin_oe : '0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			speaker_out <= 1'b0;
			speaker_oe <= 1'b0;
		end else begin
			case (mode_d)
				MODE_NORMAL: begin
					speaker_out <= core_speaker_out;
					speaker_oe <= 1'b1;
				end
				MODE_CONNECT: begin
					speaker_out <= tree_result;
					speaker_oe <= 1'b1;
				end
				default: begin
					speaker_out <= 1'b0;
					speaker_oe <= 1'b0;
				end
			endcase
		end
	end

	// Fast clock is held low outside normal operation, never floated
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fast_osc_out <= 1'b0;
		end else begin
			fast_osc_out <= pads_live(mode_d) && fast_clock_source;
		end
	end

	// Slow oscillator passes through in all modes; jitter is one clock
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			slow_osc_out <= 1'b0;
		end else begin
			slow_osc_out <= slow_osc_f;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hiz_active <= 1'b0;
			connect_active <= 1'b0;
			captured_code <= DATA_RESET;
		end else begin
			hiz_active <= (mode_d == MODE_HIZ);
			connect_active <= (mode_d == MODE_CONNECT);
			captured_code <= code_d;
		end
	end

endmodule

// File: dv/board_test_sva.sv
// Checker for the board test mode control block
`timescale 1ns/1ns
module board_test_sva #(
	parameter int PINS = 32
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic power_ok_input,
	input wire logic [7:0] peripheral_data_bus,
	input wire logic standby_reset_n,
	input wire logic slow_osc_in,
	input wire logic [PINS-1:0] pin_in,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic speaker_out,
	input wire logic speaker_oe,
	input wire logic fast_osc_out,
	input wire logic slow_osc_out,
	input wire logic hiz_active,
	input wire logic connect_active,
	input wire logic [7:0] captured_code
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	wire tree = (&pin_in) & (&peripheral_data_bus) & standby_reset_n;
	property p_float;
		hiz_active |-> pin_oe == '0 && !speaker_oe && !fast_osc_out;
	endproperty
	a_float: assert property (p_float) else $error("pins driven in hiz");
	property p_enter;
		$rose(hiz_active) |-> !$past(power_ok_input, 3);
	endproperty
	a_enter: assert property (p_enter) else $error("hiz without power low");
	// Eight quiet cycles cover the filter lag
	property p_slow;
		$stable(slow_osc_in)[*8] |-> slow_osc_out == slow_osc_in;
	endproperty
	a_slow: assert property (p_slow) else $error("slow clock not followed");
	property p_drive;
		connect_active |-> speaker_oe && !hiz_active;
	endproperty
	a_drive: assert property (p_drive) else $error("speaker not driven");
	property p_code;
		$rose(connect_active) |-> captured_code == 8'hFE;
	endproperty
	a_code: assert property (p_code) else $error("wrong entry code");
	property p_tree;
		(connect_active && $stable(tree))[*8] |-> speaker_out == tree;
	endproperty
	a_tree: assert property (p_tree) else $error("speaker not tree");
	property p_exit;
		$fell(connect_active) |-> hiz_active || captured_code == 8'h00;
	endproperty
	a_exit: assert property (p_exit) else $error("bad exit");
	property p_normal;
		power_ok_input[*8] |-> !hiz_active;
	endproperty
	a_normal: assert property (p_normal) else $error("hiz with power");
	c_conn: cover property ($rose(connect_active));
	c_hiz: cover property ($rose(hiz_active));
	c_exit: cover property ($fell(connect_active));
endmodule
bind board_test_mode_control board_test_sva #(.PINS(PINS)) chk (.clock,
	.resetn, .power_ok_input, .peripheral_data_bus, .standby_reset_n,
	.slow_osc_in, .pin_in, .pin_oe, .speaker_out, .speaker_oe, .fast_osc_out,
	.slow_osc_out, .hiz_active, .connect_active, .captured_code);

// File: dv/board_tester.sv
// Board tester model driving the test pins
`timescale 1ns/1ns
module board_tester (
	input wire logic clock,
	output logic power_ok = 1'b1,
	output logic strobe_n = 1'b1,
	output logic [7:0] data = 8'hFF,
	output logic standby_n = 1'b1
);
	task automatic hold(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic set_power(input logic v);
		hold(1);
		power_ok = v;
		if (!v) begin
			hold(3);
			standby_n = 1'b0;
			hold(3);
			standby_n = 1'b1;
		end
		hold(8);
	endtask
	// Code held three cycles each side, just past the 50 ns margin
	task automatic send_code(input logic [7:0] c);
		hold(1);
		data = c;
		hold(3);
		strobe_n = 1'b0;
		hold(3);
		strobe_n = 1'b1;
		hold(3);
		data = 8'hFF;
		hold(8);
	endtask
endmodule

// File: dv/tb.sv
// Self-checking testbench for the board test mode control block
`timescale 1ns/1ns
module tb;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic slow_in = 1'b0;
	logic [31:0] pins = '1;
	logic [31:0] pin_oe;
	logic [31:0] pin_out;
	logic [31:0] core_out = 32'hA5A50F0F;
	logic [31:0] core_oe = '1;
	logic core_spk = 1'b1;
	logic fast_src = 1'b1;
	logic spk, spk_oe, fast, hiz, conn, slow_out;
	logic [7:0] code;
	wire power_ok, strobe_n, standby_n;
	wire [7:0] data;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	always #10 clock = ~clock;
	// Slow oscillator stand-in, moved just after an edge like all stimulus
	always begin
		repeat (16) @(posedge clock);
		#2;
		slow_in = ~slow_in;
	end
	board_tester tester (.clock(clock), .power_ok(power_ok),
		.strobe_n(strobe_n), .data(data), .standby_n(standby_n));
	board_test_mode_control uut (.clock(clock), .resetn(resetn),
		.power_ok_input(power_ok), .gate_a20_mask_pin(strobe_n),
		.peripheral_data_bus(data), .standby_reset_n(standby_n),
		.fast_clock_source(fast_src), .slow_osc_in(slow_in),
		.core_pin_out(core_out), .core_pin_oe(core_oe),
		.core_speaker_out(core_spk), .pin_in(pins), .pin_out(pin_out),
		.pin_oe(pin_oe), .speaker_out(spk), .speaker_oe(spk_oe),
		.fast_osc_out(fast), .slow_osc_out(slow_out),
		.hiz_active(hiz), .connect_active(conn),
		.captured_code(code));
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic t_connect;
		tester.set_power(1'b0);
		check("hiz", {hiz, fast, spk_oe}, 3'b100);
		check("oe", pin_oe, '0);
		@(slow_in);
		tester.hold(6);
		check("slow", slow_out, slow_in);
		tester.send_code(8'hFE);
		check("conn", {conn, hiz, spk, code}, {3'b101, 8'hFE});
		pins[5] = 1'b0;
		tester.hold(8);
		check("tree", spk, 1'b0);
		pins[5] = 1'b1;
		tester.send_code(8'h5A);
		check("other", {conn, spk, code}, {2'b11, 8'h5A});
		$display("connect test done");
	endtask
	task automatic t_power_exit;
		tester.set_power(1'b1);
		check("stay", {conn, hiz}, 2'b10);
		tester.set_power(1'b0);
		check("exit", {conn, hiz}, 2'b01);
		tester.set_power(1'b1);
		check("normal", {conn, hiz, spk_oe, fast}, 4'b0011);
		check("oe", pin_oe, '1);
		check("out", pin_out, 32'hA5A50F0F);
		core_oe = 32'h0000FFFF;
		core_out = 32'h5A5AF0F0;
		core_spk = 1'b0;
		fast_src = 1'b0;
		tester.hold(1);
		check("pass", {spk, fast, spk_oe}, 3'b001);
		check("oe2", pin_oe, 32'h0000FFFF);
		check("out2", pin_out, 32'h5A5AF0F0);
		core_oe = '1;
		core_spk = 1'b1;
		fast_src = 1'b1;
		$display("power exit test done");
	endtask
	task automatic t_code_exit;
		tester.send_code(8'hFE);
		check("refused", conn, 1'b0);
		tester.set_power(1'b0);
		tester.send_code(8'hFE);
		tester.set_power(1'b1);
		tester.send_code(8'h00);
		check("code exit", {conn, hiz, code}, 10'h000);
		tester.set_power(1'b0);
		tester.send_code(8'h00);
		check("ignored", {conn, hiz}, 2'b01);
		tester.send_code(8'hFE);
		tester.send_code(8'h00);
		check("low exit", {conn, hiz, code}, 10'h100);
		tester.set_power(1'b1);
		check("back", {conn, hiz}, 2'b00);
		$display("code exit test done");
	endtask
	initial begin
		repeat (20) @(posedge clock);
		#2;
		resetn = 1'b1;
		t_connect();
		t_power_exit();
		t_code_exit();
		close_out();
	end
endmodule
